// ===== crsc_pkg.sv
package crsc_pkg;

	// ****************************************************
	// register map, byte addresses
	// ****************************************************
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_FLAG   = 4'h8;

	// control register fields
	localparam int CTRL_SOFT_KILL    = 0;
	localparam int CTRL_CPU_RST_EN   = 1;
	localparam int CTRL_BOARD_RST_EN = 2;
	localparam int CTRL_REPORT_CPU   = 3;
	localparam int CTRL_REPORT_BOARD = 4;
	localparam int CTRL_RESTORE_EN   = 5;
	localparam int CTRL_SYNC_MASTER  = 6;
	localparam int CTRL_W            = 7;
	localparam logic [6:0] CTRL_RESET = 7'h00;

	// flag register fields
	localparam int FLAG_RESET_SEEN = 0;
	localparam int FLAG_LAST_BOARD = 1;

	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_KHZ          = 25000;
	localparam int CPU_RST_MS       = 100;
	localparam int BOARD_EXTRA_MS   = 900;
	localparam int REM_OUT_DELAY_MS = 3000;
	localparam int CPU_RST_CYC      = CPU_RST_MS * CLK_KHZ;
	localparam int BOARD_RST_CYC    = (CPU_RST_MS + BOARD_EXTRA_MS) * CLK_KHZ;
	localparam int REM_OUT_CYC      = REM_OUT_DELAY_MS * CLK_KHZ;
	localparam int SYNC_KHZ         = 1250;
	localparam int SYNC_HALF_CYC    = CLK_KHZ / (2 * SYNC_KHZ);
	localparam int CNT_W            = 28;

	// pin inputs bundled for synchronising
	localparam int PIN_W = 15;

	// ****************************************************
	// encodings
	// ****************************************************
	localparam logic [1:0] KEY_OFF    = 2'h0;
	localparam logic [1:0] KEY_LOCAL  = 2'h1;
	localparam logic [1:0] KEY_REMOTE = 2'h2;
	localparam logic [1:0] EN_DISABLE = 2'h0;
	localparam logic [1:0] EN_LOCAL   = 2'h1;
	localparam logic [1:0] EN_REMOTE  = 2'h2;

	typedef enum logic [1:0] {
		CRSC_RST_IDLE,
		CRSC_RST_PRESSED,
		CRSC_RST_WAIT_LOW
	} crsc_rst_state_t;

endpackage : crsc_pkg

// ===== crsc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module crsc_pin_sync (
	input  wire logic                     clk_sys,
	input  wire logic                     arst_n,
	input  wire logic [crsc_pkg::PIN_W-1:0] pin_in,
	output logic      [crsc_pkg::PIN_W-1:0] pin_out
);

	// ****************************************************
	// three-flop synchroniser with agreement filter
	// ****************************************************
	genvar i;
	generate
		for (i = 0; i < crsc_pkg::PIN_W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			// first flop feeds only the second one
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
				end else begin
					s1_q <= pin_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
				end
			end
			// a change counts once two settled stages agree
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					pin_out[i] <= 1'b0;
				end else if (s2_q == s3_q) begin
					pin_out[i] <= s3_q;
				end
			end
		end
	endgenerate

endmodule : crsc_pin_sync
`default_nettype wire

// ===== crsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module crsc_top #(
	parameter int CPU_RST_CYC   = crsc_pkg::CPU_RST_CYC,
	parameter int BOARD_RST_CYC = crsc_pkg::BOARD_RST_CYC,
	parameter int REM_OUT_CYC   = crsc_pkg::REM_OUT_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	// register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [31:0] reg_rdata,
	// front-panel and connector inputs
	input  wire logic       main_switch_on,
	input  wire logic [1:0] power_key_pos,
	input  wire logic       remote_power_in,
	input  wire logic [1:0] enable_switch_pos,
	input  wire logic       ext_enable_in,
	input  wire logic       voltage_setpoint_select,
	input  wire logic       current_limit_select,
	input  wire logic       kill_in,
	input  wire logic       reset_in,
	input  wire logic       interlock_contact_closed,
	input  wire logic       interlock_trip_on_closed,
	input  wire logic       standard_switch_nim,
	input  wire logic       chan_on_request,
	// power and signalling standard
	output logic            system_power_on,
	output logic            remote_power_out,
	output logic            status_std_nim,
	output logic            nim_led,
	output logic            ttl_led,
	// channel control toward the boards
	output logic            local_enable_position,
	output logic            remote_enable_position,
	output logic            channels_enabled,
	output logic            use_setpoint_one,
	output logic            voltage_select_led,
	output logic            use_limit_one,
	output logic            current_select_led,
	output logic            kill_led,
	output logic            fast_off,
	output logic            interlock_led,
	output logic            chan_on_grant,
	// reset outputs
	output logic            cpu_reset_pulse,
	output logic            board_reset_pulse,
	output logic            reset_led_red,
	output logic            reset_led_orange,
	output logic            reset_flag_out,
	output logic            restore_channels,
	output logic            clear_channels,
	// supply sync clock pin
	input  wire logic       supply_sync_clock_in,
	output logic            supply_sync_clock_out,
	output logic            supply_sync_clock_oe,
	output logic            supply_sync_clock_rx,
	output logic            master_led
);

	// ****************************************************
	// pin synchronisation
	// ****************************************************
	logic [crsc_pkg::PIN_W-1:0] pins_raw;
	logic [crsc_pkg::PIN_W-1:0] pins;

	assign pins_raw = {main_switch_on, supply_sync_clock_in,
		standard_switch_nim, interlock_trip_on_closed,
		interlock_contact_closed, reset_in,
		kill_in, current_limit_select, voltage_setpoint_select,
		ext_enable_in, enable_switch_pos, remote_power_in,
		power_key_pos};

	crsc_pin_sync u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.pin_in  (pins_raw),
		.pin_out (pins)
	);

	logic [1:0] key_s;
	logic       rem_in_s;
	logic [1:0] en_pos_s;
	logic       ext_en_s;
	logic       voltage_setpoint_select_s;
	logic       current_limit_select_s;
	logic       kill_s;
	logic       rst_s;
	logic       ilk_closed_s;
	logic       ilk_pol_s;
	logic       nim_s;
	logic       sync_in_s;
	logic       main_s;

	assign key_s        = pins[1:0];
	assign rem_in_s     = pins[2];
	assign en_pos_s     = pins[4:3];
	assign ext_en_s     = pins[5];
	assign voltage_setpoint_select_s       = pins[6];
	assign current_limit_select_s       = pins[7];
	assign kill_s       = pins[8];
	assign rst_s        = pins[9];
	assign ilk_closed_s = pins[10];
	assign ilk_pol_s    = pins[11];
	assign nim_s        = pins[12];
	assign sync_in_s    = pins[13];
	assign main_s       = pins[14];

	// ****************************************************
	// registers
	// ****************************************************
	logic [crsc_pkg::CTRL_W-1:0] ctrl_q;
	logic                        flag_q;
	logic                        last_board_q;
	logic                        interlock_active;
	logic                        kill_active;
	logic                        flag_set;
	logic                        flag_clr;

	// software writes to the control register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= crsc_pkg::CTRL_RESET;
		end else if (reg_wr && reg_addr == crsc_pkg::ADDR_CTRL) begin
			ctrl_q <= reg_wdata[crsc_pkg::CTRL_W-1:0];
		end
	end

	assign flag_clr = reg_wr && reg_addr == crsc_pkg::ADDR_FLAG
		&& reg_wdata[crsc_pkg::FLAG_RESET_SEEN];

	// reset flag: a new reset in the clearing cycle is kept
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= 1'b0;
		end else if (flag_set) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// read data stands one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				crsc_pkg::ADDR_CTRL:   reg_rdata <= {25'h0, ctrl_q};
				crsc_pkg::ADDR_STATUS: reg_rdata <= {21'h0,
					interlock_active, kill_active, channels_enabled,
					use_limit_one, use_setpoint_one, reset_led_orange,
					reset_led_red, remote_power_out, status_std_nim,
					master_led, system_power_on};
				crsc_pkg::ADDR_FLAG:   reg_rdata <= {30'h0, last_board_q,
					flag_q};
				default:               reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// ****************************************************
	// power-on and cascade
	// ****************************************************
	logic [crsc_pkg::CNT_W-1:0] rem_cnt_q;

	// main switch gates both local and remote turn-on
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			system_power_on <= 1'b0;
		end else begin
			system_power_on <= main_s
				&& ((key_s == crsc_pkg::KEY_LOCAL)
				|| (key_s == crsc_pkg::KEY_REMOTE && rem_in_s));
		end
	end

	// cascade output waits a few seconds of steady power-in
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rem_cnt_q        <= '0;
			remote_power_out <= 1'b0;
		end else if (!rem_in_s) begin
			rem_cnt_q        <= '0;
			remote_power_out <= 1'b0;
		end else if (rem_cnt_q >= crsc_pkg::CNT_W'(REM_OUT_CYC - 1)) begin
			remote_power_out <= 1'b1;
		end else begin
			rem_cnt_q <= rem_cnt_q + 1'b1;
		end
	end

	// ****************************************************
	// signalling standard and setpoint selection
	// ****************************************************
	// only status outputs follow this switch; inputs stay as they are
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status_std_nim <= 1'b0;
			nim_led        <= 1'b0;
			ttl_led        <= 1'b0;
		end else begin
			status_std_nim <= nim_s;
			nim_led        <= nim_s;
			ttl_led        <= !nim_s;
		end
	end

	// boards ramp on select change, so no step is driven here
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			use_setpoint_one   <= 1'b0;
			voltage_select_led <= 1'b0;
			use_limit_one      <= 1'b0;
			current_select_led <= 1'b0;
		end else begin
			use_setpoint_one   <= voltage_setpoint_select_s;
			voltage_select_led <= voltage_setpoint_select_s;
			use_limit_one      <= current_limit_select_s;
			current_select_led <= current_limit_select_s;
		end
	end

	// ****************************************************
	// enable, kill and interlock
	// ****************************************************
	logic en_local;
	logic en_remote;

	assign en_local  = en_pos_s == crsc_pkg::EN_LOCAL;
	assign en_remote = en_pos_s == crsc_pkg::EN_REMOTE;

	// boards ramp up on rise, ramp down on fall, keeping channel state
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			local_enable_position  <= 1'b0;
			remote_enable_position <= 1'b0;
			channels_enabled       <= 1'b0;
		end else begin
			local_enable_position  <= en_local;
			remote_enable_position <= en_remote && ext_en_s;
			channels_enabled       <= en_local
				|| (en_remote && ext_en_s);
		end
	end

	// trip when contact matches the chosen polarity
	assign interlock_active = ilk_pol_s ? ilk_closed_s : !ilk_closed_s;
	assign kill_active = kill_s || ctrl_q[crsc_pkg::CTRL_SOFT_KILL];

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			kill_led      <= 1'b0;
			interlock_led <= 1'b0;
			fast_off      <= 1'b0;
		end else begin
			kill_led      <= kill_s;
			interlock_led <= interlock_active;
			fast_off      <= kill_active || interlock_active;
		end
	end

	// turn-on requests pass only while no interlock stands
	assign chan_on_grant = chan_on_request && !interlock_active;

	// ****************************************************
	// reset duration classification
	// ****************************************************
	crsc_pkg::crsc_rst_state_t rst_state_q;
	logic [crsc_pkg::CNT_W-1:0] rst_cnt_q;
	logic                       past_cpu;
	logic                       past_board;
	logic                       do_cpu;
	logic                       do_board;
	logic                       release_ev;

	assign past_cpu   = rst_cnt_q >= crsc_pkg::CNT_W'(CPU_RST_CYC);
	assign past_board = rst_cnt_q >= crsc_pkg::CNT_W'(BOARD_RST_CYC);
	assign release_ev = rst_state_q == crsc_pkg::CRSC_RST_PRESSED && !rst_s;

	// count cycles while held; short presses fall through
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_state_q <= crsc_pkg::CRSC_RST_IDLE;
			rst_cnt_q   <= '0;
		end else begin
			case (rst_state_q)
				crsc_pkg::CRSC_RST_IDLE: begin
					rst_cnt_q <= '0;
					if (rst_s) begin
						rst_state_q <= crsc_pkg::CRSC_RST_PRESSED;
					end
				end
				crsc_pkg::CRSC_RST_PRESSED: begin
					if (!rst_s) begin
						rst_state_q <= crsc_pkg::CRSC_RST_WAIT_LOW;
					end else if (!past_board) begin
						rst_cnt_q <= rst_cnt_q + 1'b1;
					end
				end
				crsc_pkg::CRSC_RST_WAIT_LOW: begin
					rst_state_q <= crsc_pkg::CRSC_RST_IDLE;
				end
				default: begin
					rst_state_q <= crsc_pkg::CRSC_RST_IDLE;
				end
			endcase
		end
	end

	// a disabled board reset falls back to the processor reset
	assign do_board = release_ev && past_board
		&& ctrl_q[crsc_pkg::CTRL_BOARD_RST_EN];
	assign do_cpu = release_ev && past_cpu && !do_board
		&& ctrl_q[crsc_pkg::CTRL_CPU_RST_EN];
	assign flag_set = (do_cpu && ctrl_q[crsc_pkg::CTRL_REPORT_CPU])
		|| (do_board && ctrl_q[crsc_pkg::CTRL_REPORT_BOARD]);

	// lamp turns red then orange as the press lengthens
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reset_led_red    <= 1'b0;
			reset_led_orange <= 1'b0;
		end else begin
			reset_led_red    <= rst_state_q == crsc_pkg::CRSC_RST_PRESSED
				&& past_cpu && !past_board;
			reset_led_orange <= rst_state_q == crsc_pkg::CRSC_RST_PRESSED
				&& past_board;
		end
	end

	// one pulse per accepted reset; board reset also resets the cpu
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cpu_reset_pulse   <= 1'b0;
			board_reset_pulse <= 1'b0;
			restore_channels  <= 1'b0;
			clear_channels    <= 1'b0;
			last_board_q      <= 1'b0;
		end else begin
			cpu_reset_pulse   <= do_cpu || do_board;
			board_reset_pulse <= do_board;
			// power-on behaviour: restore after either reset, clear only after a board reset
			restore_channels  <= (do_cpu || do_board)
				&& ctrl_q[crsc_pkg::CTRL_RESTORE_EN];
			clear_channels    <= do_board
				&& !ctrl_q[crsc_pkg::CTRL_RESTORE_EN];
			if (do_cpu || do_board) begin
				last_board_q <= do_board;
			end
		end
	end

	assign reset_flag_out = flag_q;

	// ****************************************************
	// supply sync clock
	// ****************************************************
	logic [4:0] sync_cnt_q;
	logic       sync_q;

	// divider only runs as master; slave leaves the pin undriven
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync_cnt_q <= 5'h0;
			sync_q     <= 1'b0;
		end else if (!ctrl_q[crsc_pkg::CTRL_SYNC_MASTER]) begin
			sync_cnt_q <= 5'h0;
			sync_q     <= 1'b0;
		end else if (sync_cnt_q == 5'(crsc_pkg::SYNC_HALF_CYC - 1)) begin
			sync_cnt_q <= 5'h0;
			sync_q     <= !sync_q;
		end else begin
			sync_cnt_q <= sync_cnt_q + 5'h1;
		end
	end

	assign supply_sync_clock_out = sync_q;
	assign supply_sync_clock_oe  = ctrl_q[crsc_pkg::CTRL_SYNC_MASTER];
	assign master_led            = ctrl_q[crsc_pkg::CTRL_SYNC_MASTER];
	assign supply_sync_clock_rx  = ctrl_q[crsc_pkg::CTRL_SYNC_MASTER]
		? sync_q : sync_in_s;

endmodule : crsc_top
`default_nettype wire

// ===== crsc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module crsc_asserts #(
	parameter int REM_OUT_CYC = 30
) (
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic       main_switch_on,
	input wire logic [1:0] power_key_pos,
	input wire logic       remote_power_in,
	input wire logic       system_power_on,
	input wire logic       remote_power_out,
	input wire logic       status_std_nim,
	input wire logic       nim_led,
	input wire logic       ttl_led,
	input wire logic       use_setpoint_one,
	input wire logic       voltage_select_led,
	input wire logic       use_limit_one,
	input wire logic       current_select_led,
	input wire logic       kill_led,
	input wire logic       fast_off,
	input wire logic       cpu_reset_pulse,
	input wire logic       board_reset_pulse,
	input wire logic       reset_led_red,
	input wire logic       reset_led_orange,
	input wire logic       supply_sync_clock_out,
	input wire logic       supply_sync_clock_oe,
	input wire logic       master_led
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// raw remote input high time; raw leads the synced copy, an upper bound
	int unsigned hi_cnt_q;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			hi_cnt_q <= 0;
		else if (!remote_power_in)
			hi_cnt_q <= 0;
		else if (hi_cnt_q < 1000)
			hi_cnt_q <= hi_cnt_q + 1;
	end

	// sync divider: ten cycles high, then low
	sequence s_high_half;
		supply_sync_clock_out [*5] ##1 supply_sync_clock_out [*5];
	endsequence

	a_main_off: assert property (!main_switch_on [*6] |-> !system_power_on)
		else $error("power on with main switch off");
	a_key_off: assert property ((power_key_pos == crsc_pkg::KEY_OFF) [*6]
		|-> !system_power_on) else $error("power on with key off");
	a_remote_delay: assert property ($rose(remote_power_out)
		|-> hi_cnt_q >= REM_OUT_CYC) else $error("remote out too early");
	a_std_lamps: assert property (nim_led == status_std_nim
		&& (!$past(arst_n) || ttl_led == !nim_led))
		else $error("standard lamps disagree");
	a_select_lamps: assert property (
		voltage_select_led == use_setpoint_one
		&& current_select_led == use_limit_one) else $error("select lamp wrong");
	a_kill_off: assert property (kill_led |-> fast_off)
		else $error("kill without fast off");
	a_board_with_cpu: assert property (
		board_reset_pulse |-> cpu_reset_pulse)
		else $error("board reset without cpu reset");
	a_short_reset: assert property (cpu_reset_pulse
		|-> reset_led_red || reset_led_orange)
		else $error("reset action after short press");
	a_sync_period: assert property ($rose(supply_sync_clock_out)
		|-> s_high_half ##1 !supply_sync_clock_out) else $error("sync period");
	a_slave_quiet: assert property (master_led == supply_sync_clock_oe
		&& (supply_sync_clock_oe || $past(supply_sync_clock_oe)
		|| !supply_sync_clock_out)) else $error("sync driven as slave");
endmodule : crsc_asserts
`default_nettype wire

// ===== crsc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module crsc_panel_model (
	input  wire logic clk_sys,
	output logic      reset_in,
	output logic      supply_sync_clock_in
);
	int ph_q;

	// idle panel: button released, foreign clock at phase zero
	initial begin
		reset_in = 1'b0;
		supply_sync_clock_in = 1'b0;
		ph_q = 0;
	end

	// foreign sync source, period 22 cycles so it never locks to ours
	always @(posedge clk_sys) begin
		ph_q <= (ph_q == 10) ? 0 : ph_q + 1;
		if (ph_q == 10)
			supply_sync_clock_in <= !supply_sync_clock_in;
	end

	// operator holds the reset button for n clock cycles
	task automatic press(input int n);
		@(posedge clk_sys);
		reset_in <= 1'b1;
		repeat (n) @(posedge clk_sys);
		reset_in <= 1'b0;
	endtask : press
endmodule : crsc_panel_model
`default_nettype wire

// ===== crsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module crsc_top_tb;
	localparam int CPU_RST_CYC = 20;
	localparam int BOARD_RST_CYC = 50;
	localparam int REM_OUT_CYC = 30;
	logic        clk_sys, arst_n, reg_wr, reg_rd, main_switch_on;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_q;
	logic [1:0]  power_key_pos, enable_switch_pos;
	logic        remote_power_in, ext_enable_in, voltage_setpoint_select;
	logic        current_limit_select, kill_in, interlock_contact_closed;
	logic        interlock_trip_on_closed, standard_switch_nim, chan_on_request;
	logic        system_power_on, remote_power_out, status_std_nim, nim_led;
	logic        ttl_led, local_enable_position, remote_enable_position;
	logic        channels_enabled, use_setpoint_one, voltage_select_led;
	logic        use_limit_one, current_select_led, kill_led, fast_off;
	logic        interlock_led, chan_on_grant, cpu_reset_pulse;
	logic        board_reset_pulse, reset_led_red, reset_led_orange;
	logic        reset_flag_out, restore_channels, clear_channels, master_led;
	logic        supply_sync_clock_out, supply_sync_clock_oe;
	logic        supply_sync_clock_rx, seen_clr;
	logic [5:0]  seen_q;
	wire logic   reset_in, supply_sync_clock_in;
	int          fails, checked;

	crsc_top #(.CPU_RST_CYC(CPU_RST_CYC), .BOARD_RST_CYC(BOARD_RST_CYC),
		.REM_OUT_CYC(REM_OUT_CYC)) uut (.*);
	crsc_panel_model panel (.clk_sys(clk_sys), .reset_in(reset_in),
		.supply_sync_clock_in(supply_sync_clock_in));

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// sticky record of reset pulses and lamps, cleared before each press
	always @(posedge clk_sys) begin
		if (seen_clr)
			seen_q <= '0;
		else
			seen_q <= seen_q | {reset_led_orange, reset_led_red,
				restore_channels, clear_channels, board_reset_pulse, cpu_reset_pulse};
	end

	// ********************************
	// helpers
	// ********************************
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic close_out();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// ********************************
	// scenarios
	// ********************************
	task automatic t_regs();
		rd(crsc_pkg::ADDR_CTRL, rd_q);
		check("ctrl reset", rd_q, 32'h0);
		wr(crsc_pkg::ADDR_CTRL, 32'h3f);
		rd(crsc_pkg::ADDR_CTRL, rd_q);
		check("ctrl back", rd_q, 32'h3f);
		rd(4'hc, rd_q);
		check("unmapped", rd_q, 32'h0);
		wr(crsc_pkg::ADDR_CTRL, 32'h0);
		$display("register test done");
	endtask : t_regs

	task automatic t_power();
		@(posedge clk_sys);
		power_key_pos <= crsc_pkg::KEY_LOCAL;
		wt(6);
		check("main off", system_power_on, 1'b0);
		@(posedge clk_sys);
		main_switch_on <= 1'b1;
		wt(6);
		check("local on", system_power_on, 1'b1);
		@(posedge clk_sys);
		power_key_pos <= crsc_pkg::KEY_REMOTE;
		wt(6);
		check("armed", system_power_on, 1'b0);
		@(posedge clk_sys);
		remote_power_in <= 1'b1;
		wt(6);
		check("remote on", system_power_on, 1'b1);
		check("out early", remote_power_out, 1'b0);
		wt(34);
		check("out late", remote_power_out, 1'b1);
		@(posedge clk_sys);
		power_key_pos <= crsc_pkg::KEY_OFF;
		remote_power_in <= 1'b0;
		wt(6);
		check("key off", {system_power_on, remote_power_out}, 2'h0);
		$display("power test done");
	endtask : t_power

	task automatic t_panel();
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			standard_switch_nim <= i[0];
			voltage_setpoint_select <= i[0];
			current_limit_select <= !i[0];
			wt(6);
			check("nim", status_std_nim, i[0]);
			check("ttl lamp", ttl_led, !i[0]);
			check("volt sel", {use_setpoint_one, voltage_select_led}, {2{i[0]}});
			check("curr sel", {use_limit_one, current_select_led}, {2{!i[0]}});
		end
		$display("panel test done");
	endtask : t_panel

	task automatic t_enable();
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			enable_switch_pos <= 2'(i / 2);
			ext_enable_in <= i[0];
			wt(6);
			check("enabled", channels_enabled, i == 2 || i == 3 || i == 5);
			check("loc lamp", local_enable_position, i / 2 == 1);
			check("rem lamp", remote_enable_position, i == 5);
		end
		$display("enable test done");
	endtask : t_enable

	task automatic t_kill();
		@(posedge clk_sys);
		kill_in <= 1'b1;
		wt(6);
		check("kill", {kill_led, fast_off}, 2'h3);
		@(posedge clk_sys);
		kill_in <= 1'b0;
		wt(6);
		check("kill gone", {kill_led, fast_off}, 2'h0);
		wr(crsc_pkg::ADDR_CTRL, 32'h1);
		wt(3);
		check("soft kill", {kill_led, fast_off}, 2'h1);
		rd(crsc_pkg::ADDR_STATUS, rd_q);
		check("kill status", rd_q[9], 1'b1);
		wr(crsc_pkg::ADDR_CTRL, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			interlock_trip_on_closed <= i[1];
			interlock_contact_closed <= i[0];
			chan_on_request <= 1'b1;
			wt(6);
			check("ilk lamp", interlock_led, i[1] == i[0]);
			check("grant", chan_on_grant, i[1] != i[0]);
			check("ilk off", fast_off, i[1] == i[0]);
		end
		@(posedge clk_sys);
		interlock_contact_closed <= 1'b0;
		$display("kill test done");
	endtask : t_kill

	task automatic t_sync();
		int n;
		logic prev;
		wr(crsc_pkg::ADDR_CTRL, 32'h40);
		wt(3);
		check("master", {supply_sync_clock_oe, master_led}, 2'h3);
		n = 0;
		prev = supply_sync_clock_out;
		repeat (80) begin
			wt(1);
			n += int'(supply_sync_clock_out && !prev);
			prev = supply_sync_clock_out;
		end
		check("sync rises", n, 4);
		for (int k = 0; k < 25 && !(prev && !supply_sync_clock_out); k++) begin
			prev = supply_sync_clock_out;
			wt(1);
		end
		wr(crsc_pkg::ADDR_CTRL, 32'h0);
		wt(3);
		check("slave", {supply_sync_clock_oe, master_led}, 2'h0);
		n = 0;
		prev = supply_sync_clock_rx;
		repeat (80) begin
			wt(1);
			n += int'(supply_sync_clock_rx && !prev);
			prev = supply_sync_clock_rx;
		end
		check("rx follows", n >= 3, 1'b1);
		check("out quiet", supply_sync_clock_out, 1'b0);
		$display("sync test done");
	endtask : t_sync

	// exp and mask order: orange, red, restore, clear, board, cpu
	task automatic one_reset(input logic [6:0] ctrl, input int len,
		input logic [5:0] exp, input logic [5:0] mask, input logic flag);
		wr(crsc_pkg::ADDR_CTRL, {25'h0, ctrl});
		wr(crsc_pkg::ADDR_FLAG, 32'h1);
		seen_clr <= 1'b1;
		@(posedge clk_sys);
		seen_clr <= 1'b0;
		panel.press(len);
		wt(12);
		check("reset seen", seen_q & mask, exp);
		rd(crsc_pkg::ADDR_FLAG, rd_q);
		check("flag", rd_q[0], flag);
		check("last board", rd_q[1], exp[1]);
		check("flag pin", reset_flag_out, flag);
	endtask : one_reset

	task automatic t_reset();
		one_reset(7'h1e, 10, 6'h00, 6'h3f, 1'b0);
		one_reset(7'h1e, 30, 6'h11, 6'h3f, 1'b1);
		one_reset(7'h1e, 70, 6'h37, 6'h3f, 1'b1);
		one_reset(7'h3e, 70, 6'h3b, 6'h3f, 1'b1);
		one_reset(7'h3e, 30, 6'h09, 6'h0f, 1'b1);
		one_reset(7'h18, 70, 6'h00, 6'h0f, 1'b0);
		one_reset(7'h0a, 70, 6'h01, 6'h0f, 1'b1);
		one_reset(7'h12, 30, 6'h01, 6'h0f, 1'b0);
		one_reset(7'h0c, 70, 6'h07, 6'h0f, 1'b0);
		$display("reset test done");
	endtask : t_reset

	// hang guard at 20000 cycles, far beyond the thousand or so cycles the tests need
	initial begin
		#(40 * 20000);
		fails++;
		close_out();
	end

	// main sequence
	initial begin
		{arst_n, reg_wr, reg_rd, main_switch_on, remote_power_in} = '0;
		{ext_enable_in, voltage_setpoint_select, current_limit_select} = '0;
		{kill_in, interlock_contact_closed, standard_switch_nim} = '0;
		{chan_on_request, seen_clr} = '0;
		interlock_trip_on_closed = 1'b1;
		{reg_addr, reg_wdata, power_key_pos, enable_switch_pos} = '0;
		{fails, checked} = '0;
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_regs();
		t_power();
		t_panel();
		t_enable();
		t_kill();
		t_sync();
		t_reset();
		close_out();
	end
endmodule : crsc_top_tb

bind crsc_top crsc_asserts #(.REM_OUT_CYC(REM_OUT_CYC)) chk (.*);
`default_nettype wire
